/* File: hw/scgcfg_bit_phy.sv */
`timescale 1ns/100ps
module scgcfg_bit_phy (
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  input  wire logic   i_scl,
  input  wire logic   i_sda,
  output logic        o_sda_oe,
  scgcfg_byte_if.phy  bus
);
  typedef enum logic [2:0] {
    SCGCF_IDLE, SCGCF_RX, SCGCF_RX_ACK, SCGCF_TX, SCGCF_TX_ACK
  } scgcf_state_t;
  scgcf_state_t state_reg;
  logic [1:0]   scl_sh_reg;
  logic [1:0]   sda_sh_reg;
  logic [7:0]   shift_reg;
  logic [3:0]   cnt_reg;
  logic         first_reg;
  logic         rd_reg;
  logic         ack_go_reg;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      scl_sh_reg <= 2'h3;
      sda_sh_reg <= 2'h3;
    end else begin
      scl_sh_reg <= {scl_sh_reg[0], i_scl};
      sda_sh_reg <= {sda_sh_reg[0], i_sda};
    end
  end
  assign scl_rise  = scl_sh_reg == 2'h1;
  assign scl_fall  = scl_sh_reg == 2'h2;
  assign start_det = scl_sh_reg[1] & scl_sh_reg[0] & (sda_sh_reg == 2'h2);
  assign stop_det  = scl_sh_reg[1] & scl_sh_reg[0] & (sda_sh_reg == 2'h1);
  assign bus.start = start_det;
  assign bus.stop  = stop_det;
  assign bus.rx_data  = shift_reg;
  assign bus.rx_first = first_reg;
  assign bus.reading  = rd_reg;
  assign bus.rx_valid = (state_reg == SCGCF_RX) & scl_fall
                        & (cnt_reg == 4'h8);
  assign bus.tx_load  = ((state_reg == SCGCF_RX_ACK) & scl_fall & rd_reg
                         & ack_go_reg)
                      | ((state_reg == SCGCF_TX_ACK) & scl_rise
                         & ~sda_sh_reg[1]);

  // target only: drives data low for ack or read zeros, never clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg  <= SCGCF_IDLE;
      shift_reg  <= 8'h00;
      cnt_reg    <= 4'h0;
      first_reg  <= 1'b0;
      rd_reg     <= 1'b0;
      ack_go_reg <= 1'b0;
      o_sda_oe   <= 1'b0;
    end else if (start_det) begin
      state_reg <= SCGCF_RX;
      cnt_reg   <= 4'h0;
      first_reg <= 1'b1;
      rd_reg    <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else if (stop_det) begin
      state_reg <= SCGCF_IDLE;
      o_sda_oe  <= 1'b0;
    end else begin
      unique case (state_reg)
        SCGCF_IDLE: o_sda_oe <= 1'b0;
        SCGCF_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sh_reg[1]};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            ack_go_reg <= ~first_reg | bus.addr_ack;
            o_sda_oe   <= ~first_reg | bus.addr_ack;
            if (first_reg)
              rd_reg <= shift_reg[0] & bus.addr_ack;
            state_reg <= SCGCF_RX_ACK;
          end
        end
        SCGCF_RX_ACK: begin
          if (scl_fall) begin
            first_reg <= 1'b0;
            cnt_reg   <= 4'h0;
            if (!ack_go_reg) begin
              state_reg <= SCGCF_IDLE;
              o_sda_oe  <= 1'b0;
            end else if (rd_reg) begin
              state_reg <= SCGCF_TX;
              shift_reg <= bus.tx_data;
              o_sda_oe  <= ~bus.tx_data[7];
            end else begin
              state_reg <= SCGCF_RX;
              o_sda_oe  <= 1'b0;
            end
          end
        end
        SCGCF_TX: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe <= ~shift_reg[7];  // msb of a follow-on byte
              cnt_reg  <= 4'h0;
            end else if (cnt_reg == 4'h7) begin
              state_reg <= SCGCF_TX_ACK;
              o_sda_oe  <= 1'b0;
              cnt_reg   <= cnt_reg + 4'h1;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              o_sda_oe  <= ~shift_reg[6];
              cnt_reg   <= cnt_reg + 4'h1;
            end
          end
        end
        SCGCF_TX_ACK: begin
          if (scl_rise) begin
            if (sda_sh_reg[1]) begin
              state_reg <= SCGCF_IDLE;  // nack ends the read
            end else begin
              state_reg <= SCGCF_TX;
              shift_reg <= bus.tx_data;
              cnt_reg   <= 4'h8;
            end
          end
        end
        default: state_reg <= SCGCF_IDLE;
      endcase
    end
  end
endmodule : scgcfg_bit_phy

/* File: hw/scgcfg_byte_if.sv */
`timescale 1ns/100ps
interface scgcfg_byte_if;
  logic       start;     // start or repeated start seen
  logic       stop;
  logic       rx_valid;  // byte received, ack being given unless address byte mismatches
  logic [7:0] rx_data;
  logic       rx_first;  // byte is the address byte
  logic       addr_ack;  // decoder: address matches
  logic       tx_load;   // request next read byte
  logic [7:0] tx_data;
  logic       reading;
  modport phy (output start, stop, rx_valid, rx_data, rx_first, tx_load,
               reading, input addr_ack, tx_data);
  modport ctl (input start, stop, rx_valid, rx_data, rx_first, tx_load,
               reading, output addr_ack, tx_data);
endinterface : scgcfg_byte_if

/* File: hw/scgcfg_pkg.sv */
package scgcfg_pkg;
  localparam logic [4:0] ADDR_HI       = 5'h1a;  // a6..a2 = 1,1,0,1,0
  localparam logic       ADDR_LSB      = 1'b0;
  localparam logic [7:0] OFS_OE        = 8'h00;
  localparam logic [7:0] OFS_SPREAD    = 8'h01;
  localparam logic [7:0] OFS_SLEW      = 8'h02;
  localparam logic [7:0] OFS_BCOUNT    = 8'h07;
  localparam logic [7:0] OFS_STOP      = 8'h0b;
  localparam logic [7:0] RST_OE        = 8'h0f;
  localparam logic [7:0] RST_SPREAD_LO = 8'h06;  // bit2 reserved 1, amp 10
  localparam logic [7:0] RST_SLEW      = 8'hff;
  localparam logic [7:0] RST_BCOUNT    = 8'h08;
  localparam logic [1:0] RST_STOP      = 2'h0;
  localparam int         SPR_RB_LSB    = 6;
  localparam int         SPR_SWSEL_BIT = 5;
  localparam int         SPR_SW_LSB    = 3;
  localparam logic [7:0] RD_FILL       = 8'h00;
  localparam logic [1:0] SPR_NONE      = 2'h0;
  localparam logic [1:0] SPR_QUARTER   = 2'h1;
  localparam logic [1:0] SPR_RESVD     = 2'h2;
  localparam logic [1:0] SPR_HALF      = 2'h3;
  localparam logic [1:0] STRAP_LOW     = 2'h0;
  localparam logic [1:0] STRAP_MID     = 2'h1;
  localparam logic [1:0] STRAP_HIGH    = 2'h3;
endpackage : scgcfg_pkg

/* File: hw/scgcfg_top.sv */
`timescale 1ns/100ps
module scgcfg_top (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic       i_addr_select_strap,
  input  wire logic [1:0] i_spread_strap,
  input  wire logic [3:0] i_pin_enable,
  output logic      [3:0] o_diff_out_run,
  output logic      [1:0] o_disable_state,
  output logic      [1:0] o_spread_code,
  output logic      [1:0] o_amplitude,
  output logic      [3:0] o_edge_rate
);
  typedef enum logic [1:0] {
    SCGC_ADDR, SCGC_INDEX, SCGC_COUNT, SCGC_DATA
  } scgc_phase_t;
  scgcfg_byte_if bus ();
  scgc_phase_t phase_reg;
  logic [7:0]  oe_reg;
  logic [5:0]  spread_reg;
  logic [7:0]  slew_reg;
  logic [4:0]  bcount_reg;
  logic [1:0]  stop_reg;
  logic [1:0]  strap_reg;
  logic        strap_done_reg;
  logic        addr_sel_reg;
  logic [7:0]  index_reg;
  logic        cnt_sent_reg;
  logic [7:0]  rd_mux;
  logic [7:0]  spread_byte;
  logic        wr_strobe;
  logic        wr_oe;
  logic        wr_spread;
  logic        wr_slew;
  logic        wr_bcount;
  logic        wr_stop;

  scgcfg_bit_phy u_phy (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_scl    (i_scl),
    .i_sda    (i_sda),
    .o_sda_oe (o_sda_oe),
    .bus      (bus)
  );
  assign o_sda_out = 1'b0;

  // straps caught once after reset release
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      strap_done_reg <= 1'b0;
      strap_reg      <= 2'h0;
      addr_sel_reg   <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg      <= i_spread_strap;
      addr_sel_reg   <= i_addr_select_strap;
    end
  end

  assign bus.addr_ack = (bus.rx_data[7:3] == scgcfg_pkg::ADDR_HI)
                      & (bus.rx_data[2] == addr_sel_reg)
                      & (bus.rx_data[1] == scgcfg_pkg::ADDR_LSB);

  // byte sequencing
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_reg    <= SCGC_ADDR;
      index_reg    <= 8'h00;
      cnt_sent_reg <= 1'b0;
    end else if (bus.start) begin
      phase_reg    <= SCGC_ADDR;
      cnt_sent_reg <= 1'b0;
    end else if (bus.rx_valid) begin
      unique case (phase_reg)
        SCGC_ADDR:
          phase_reg <= bus.rx_data[0] ? SCGC_DATA : SCGC_INDEX;
        SCGC_INDEX: begin
          index_reg <= bus.rx_data;
          phase_reg <= SCGC_COUNT;
        end
        SCGC_COUNT: phase_reg <= SCGC_DATA;
        SCGC_DATA:  index_reg <= index_reg + 8'h01;
      endcase
    end else if (bus.tx_load) begin
      if (cnt_sent_reg)
        index_reg <= index_reg + 8'h01;
      cnt_sent_reg <= 1'b1;
    end
  end

  // one strobe per whole data byte, so an early stop keeps the rest
  assign wr_strobe = bus.rx_valid & (phase_reg == SCGC_DATA)
                   & ~bus.reading & ~bus.rx_first;
  assign wr_oe     = wr_strobe & (index_reg == scgcfg_pkg::OFS_OE);
  assign wr_spread = wr_strobe & (index_reg == scgcfg_pkg::OFS_SPREAD);
  assign wr_slew   = wr_strobe & (index_reg == scgcfg_pkg::OFS_SLEW);
  assign wr_bcount = wr_strobe & (index_reg == scgcfg_pkg::OFS_BCOUNT);
  assign wr_stop   = wr_strobe & (index_reg == scgcfg_pkg::OFS_STOP);

  // reserved enable bits keep their reset value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      oe_reg <= scgcfg_pkg::RST_OE;
    end else if (wr_oe) begin
      oe_reg[3:0] <= bus.rx_data[3:0];
    end
  end

  // readback bits live in strap_reg, bit 2 stays 1
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      spread_reg <= scgcfg_pkg::RST_SPREAD_LO[5:0];
    end else if (wr_spread) begin
      spread_reg[5:3] <= bus.rx_data[5:3];
      spread_reg[1:0] <= bus.rx_data[1:0];
    end
  end

  // reserved slew bits stay 1
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      slew_reg <= scgcfg_pkg::RST_SLEW;
    end else if (wr_slew) begin
      slew_reg[3:0] <= bus.rx_data[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bcount_reg <= scgcfg_pkg::RST_BCOUNT[4:0];
    end else if (wr_bcount) begin
      bcount_reg <= bus.rx_data[4:0];
    end
  end

  // stop field, upper bits reserved
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stop_reg <= scgcfg_pkg::RST_STOP;
    end else if (wr_stop) begin
      stop_reg <= bus.rx_data[1:0];
    end
  end

  assign spread_byte = {strap_reg, spread_reg};
  // read mux, unmapped indexes give the fill value
  always_comb begin
    unique case (index_reg)
      scgcfg_pkg::OFS_OE:     rd_mux = oe_reg;
      scgcfg_pkg::OFS_SPREAD: rd_mux = spread_byte;
      scgcfg_pkg::OFS_SLEW:   rd_mux = slew_reg;
      scgcfg_pkg::OFS_BCOUNT: rd_mux = {3'h0, bcount_reg};
      scgcfg_pkg::OFS_STOP:   rd_mux = {6'h00, stop_reg};
      default:                rd_mux = scgcfg_pkg::RD_FILL;
    endcase
  end
  // first read byte is the count, then data from the index
  assign bus.tx_data = cnt_sent_reg ? rd_mux : {3'h0, bcount_reg};

  // per-output run gate and edge rate, registered
  for (genvar g = 0; g < 4; g++) begin : g_out
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        o_diff_out_run[g] <= 1'b0;
        o_edge_rate[g]    <= scgcfg_pkg::RST_SLEW[g];
      end else begin
        o_diff_out_run[g] <= oe_reg[g] & i_pin_enable[g];
        o_edge_rate[g]    <= slew_reg[g];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_disable_state <= scgcfg_pkg::RST_STOP;
    end else begin
      o_disable_state <= stop_reg;
    end
  end

  // software code only while the select bit is set
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_spread_code <= scgcfg_pkg::SPR_NONE;
    end else begin
      o_spread_code <= spread_reg[scgcfg_pkg::SPR_SWSEL_BIT]
                       ? spread_reg[4:3] : strap_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_amplitude <= scgcfg_pkg::RST_SPREAD_LO[1:0];
    end else begin
      o_amplitude <= spread_reg[1:0];
    end
  end
endmodule : scgcfg_top

/* File: sim/scgcfg_host_model.sv */
`timescale 1ns/100ps
module scgcfg_host_model (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // one bus phase, ten clocks long
  task automatic ph(input logic c, input logic l);
    o_scl = c;
    o_sda_low = l;
    repeat (10) @(posedge i_clock);
    #1;
  endtask : ph
  task automatic start_cond();
    ph(1'b0, o_sda_low);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask : start_cond
  task automatic stop_cond();
    ph(1'b0, o_sda_low);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : stop_cond
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, o_sda_low);
    ph(1'b0, ~b);
    ph(1'b1, ~b);
    r = i_sda;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : scgcfg_host_model

/* File: sim/scgcfg_top_asserts.sv */
`timescale 1ns/100ps
module scgcfg_top_asserts (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic [3:0] i_pin_enable,
  input wire logic [3:0] o_diff_out_run,
  input wire logic [1:0] o_disable_state,
  input wire logic [1:0] o_spread_code,
  input wire logic [1:0] o_amplitude,
  input wire logic [3:0] o_edge_rate
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  AST_RST_OE: assert property (disable iff (1'b0)
    i_rst |=> !o_sda_oe) else $error("data driven in reset");
  AST_RST_DRIVE: assert property (disable iff (1'b0)
    i_rst |=> o_amplitude == 2'h2 && o_edge_rate == 4'hf)
    else $error("bad reset drive");
  AST_RST_STOP: assert property (disable iff (1'b0)
    i_rst |=> o_disable_state == 2'h0) else $error("bad reset stop");
  AST_RST_SPREAD: assert property (disable iff (1'b0)
    i_rst |=> o_spread_code == 2'h0) else $error("bad reset spread");
  AST_RUN_PIN: assert property (
    !$past(i_rst) |-> (o_diff_out_run & ~$past(i_pin_enable)) == 4'h0)
    else $error("output runs with pin low");
  AST_OPEN_DRAIN: assert property (o_sda_out == 1'b0)
    else $error("data driven high");
  AST_OE_SCL_LOW: assert property (
    $changed(o_sda_oe) |-> !i_scl) else $error("data moved in clock high");
  AST_IDLE_STABLE: assert property (
    (i_scl && i_sda) [*8] |=> $stable(o_amplitude) && $stable(o_edge_rate)
    && $stable(o_disable_state)) else $error("config moved on idle bus");

  cover property ($rose(o_sda_oe));
  cover property (o_spread_code == 2'h3);
  cover property (o_disable_state == 2'h3);
endmodule : scgcfg_top_asserts

bind scgcfg_top scgcfg_top_asserts u_scgcfg_top_asserts (
  .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_pin_enable(i_pin_enable),
  .o_diff_out_run(o_diff_out_run), .o_disable_state(o_disable_state),
  .o_spread_code(o_spread_code), .o_amplitude(o_amplitude),
  .o_edge_rate(o_edge_rate)
);

/* File: sim/smbus_clock_config_slave_test.sv */
`timescale 1ns/100ps
module smbus_clock_config_slave_test;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       a1  = 1'b1;
  logic [1:0] ss  = scgcfg_pkg::STRAP_MID;
  logic [3:0] pin = 4'hf;
  logic       low;
  logic       oe;
  logic       scl;
  logic       sda;
  logic [3:0] run;
  logic [1:0] dis;
  logic [1:0] spr;
  logic [1:0] amp;
  logic [3:0] slew;
  logic [7:0] aw;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc = 0;
  always #5 clk = ~clk;
  assign sda = ~(low | oe);  // pull-up
  assign aw = {scgcfg_pkg::ADDR_HI, a1, scgcfg_pkg::ADDR_LSB, 1'b0};
  scgcfg_top u_scgcfg_top (
    .i_clock(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(),
    .o_sda_oe(oe), .i_addr_select_strap(a1), .i_spread_strap(ss),
    .i_pin_enable(pin), .o_diff_out_run(run), .o_disable_state(dis),
    .o_spread_code(spr), .o_amplitude(amp), .o_edge_rate(slew));
  scgcfg_host_model u_host (
    .i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(low));
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s: %h not %h", $time, m, g, e);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d);
    logic a;
    u_host.wr_byte(d, a);
    chk(8'(a), 8'h01, "no ack");
  endtask : tx
  task automatic wr(input logic [7:0] i, n, input logic [7:0] q[$]);
    u_host.start_cond();
    tx(aw);
    tx(i);
    tx(n);
    foreach (q[k]) tx(q[k]);
    u_host.stop_cond();
    repeat (4) @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] q[$]);
    logic [7:0] d;
    u_host.start_cond();
    tx(aw);
    tx(i);
    u_host.start_cond();
    tx(aw | 8'h01);
    u_host.rd_byte(1'b0, d);
    chk(d, scgcfg_pkg::RST_BCOUNT, "count");
    foreach (q[k]) begin
      u_host.rd_byte(k == q.size() - 1, d);
      chk(d, q[k], "read");
    end
    u_host.stop_cond();
  endtask : rd
  task automatic do_rst();
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_rst
  task automatic t_defaults();
    chk({4'h0, run}, 8'h0f, "run");
    chk({6'h0, spr}, {6'h0, ss}, "spread");
    chk({6'h0, amp}, 8'h02, "amp");
    chk({4'h0, slew}, 8'h0f, "slew");
    chk({6'h0, dis}, 8'h00, "stop");
    rd(scgcfg_pkg::OFS_OE, '{8'h0f, {ss, 6'h06}, 8'hff});
  endtask : t_defaults
  task automatic t_write();
    wr(scgcfg_pkg::OFS_OE, 8'h03, '{8'h05, 8'hf9, 8'hf5});
    chk({4'h0, run}, 8'h05, "run");
    chk({6'h0, spr}, 8'h03, "half");
    chk({6'h0, amp}, 8'h01, "amp");
    chk({4'h0, slew}, 8'h05, "slew");
    rd(scgcfg_pkg::OFS_OE, '{8'h05, {ss, 6'h3d}, 8'hf5});
    pin = 4'h3;
    repeat (3) @(posedge clk);
    #1;
    chk({4'h0, run}, 8'h01, "pin");
    pin = 4'hf;
  endtask : t_write
  task automatic t_spread();
    wr(scgcfg_pkg::OFS_SPREAD, 8'h01, '{8'h2a});
    chk({6'h0, spr}, 8'h01, "quarter");
    wr(scgcfg_pkg::OFS_SPREAD, 8'h01, '{8'h06});
    chk({6'h0, spr}, {6'h0, ss}, "strap");
    wr(scgcfg_pkg::OFS_SPREAD, 8'h01, '{8'h22});
    chk({6'h0, spr}, 8'h00, "off");
    do_rst();
    chk({6'h0, spr}, {6'h0, ss}, "rst");
    chk({4'h0, run}, 8'h0f, "run");
  endtask : t_spread
  task automatic t_stop();
    for (int k = 0; k < 4; k++) begin
      wr(scgcfg_pkg::OFS_STOP, 8'h01, '{8'(k)});
      chk({6'h0, dis}, 8'(k), "stop state");
    end
  endtask : t_stop
  task automatic t_abort();
    logic a;
    wr(scgcfg_pkg::OFS_SLEW, 8'h02, '{8'hf3});
    chk({4'h0, slew}, 8'h03, "slew");
    u_host.start_cond();
    u_host.wr_byte(aw ^ 8'h04, a);
    chk(8'(a), 8'h00, "foreign ack");
    u_host.stop_cond();
    rd(scgcfg_pkg::OFS_SLEW, '{8'hf3});
  endtask : t_abort
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    do_rst();
    t_defaults();
    t_write();
    t_spread();
    t_stop();
    t_abort();
    summarize();
  end
endmodule : smbus_clock_config_slave_test
